// file: design/nibble_exec.sv
// nibble cpu execution unit with axi4-lite access
`timescale 1ns/1ns
`default_nettype none
`include "nibble_exec_regs.svh"
module nibble_exec (
   // clock and reset
   input  wire logic                   mclk_i,
   input  wire logic                   resetn_i,
   // instruction byte stream from fetch
   input  wire logic                   byte_valid_i,
   input  wire logic [7:0]             byte_i,
   // architectural state
   output logic [3:0]                  work_reg_o,
   output logic [3:0]                  ext_reg_o,
   output logic                        carry_bit_o,
   output logic                        zero_bit_o,
   output nibble_exec_pkg::fetch_state_t state_o,
   // axi4-lite slave
   input  wire logic [11:0]            s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [11:0]            s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready
);
   import nibble_exec_pkg::*;

   // ==========
   // state
   logic [3:0]   work_q, ext_q;
   logic         carry_q, zero_q, skip_q;
   logic [7:0]   primary_pointer_q, auxiliary_pointer_q, first_q;
   fetch_state_t state_q;
   nibble_t      mem_q [256];

   // ==========
   // operand fetch from data memory
   wire logic [7:0] ptr_next     = primary_pointer_q + 8'h01;
   wire nibble_t    m_hl         = mem_q[primary_pointer_q];
   wire nibble_t    m_xy         = mem_q[auxiliary_pointer_q];
   wire nibble_t    m_direct     = mem_q[byte_i];
   wire nibble_t    m_sel        = byte_i[1] ? m_xy : m_hl;
   wire logic [3:0] bit_mask     = 4'h1 << byte_i[1:0];
   wire logic [3:0] primary_pointer_low = primary_pointer_q[3:0];

   // adders and a subtractor, all five bits wide with the carry or borrow out in bit 4
   wire logic [4:0] add_mem      = {1'b0, work_q} + {1'b0, m_hl};
   wire logic [4:0] add_mem_c    = add_mem + {4'h0, carry_q};
   wire logic [4:0] sub_mem      = {1'b0, m_hl} - {1'b0, work_q} - {4'h0, ~carry_q};
   wire logic [4:0] add_imm      = {1'b0, work_q} + {1'b0, byte_i[3:0]};
   wire logic [4:0] inc_direct   = {1'b0, m_direct} + 5'h01;
   wire logic [4:0] dec_direct   = {1'b0, m_direct} + 5'h0F;

   // ==========
   // decode of the current byte
   wire logic two_byte   = (state_q == FETCH_SECOND);
   wire logic is_prefix  = (byte_i[7:4] == `HI_PREFIX);
   wire logic is_lai     = (byte_i[7:4] == `HI_LAI);
   wire logic sub_cmb    = (byte_i[7:2] == `SUB_CMB);
   wire logic exec_one   = byte_valid_i && !two_byte && !is_prefix;
   wire logic exec_two   = byte_valid_i && two_byte;

   // ==========
   // next state of work, ext, flags and memory writes
   logic [3:0] work_d, ext_d, wdata_a, wdata_b;
   logic       carry_d, zero_d, we_a, we_b;
   logic [7:0] waddr_a;
   always_comb begin
      work_d  = work_q;
      ext_d   = ext_q;
      carry_d = carry_q;
      zero_d  = zero_q;
      we_a    = 1'b0;
      we_b    = 1'b0;
      waddr_a = primary_pointer_q;
      wdata_a = 4'h0;
      wdata_b = ext_q;
      if (exec_one) begin
         if (is_lai) begin
            // clear is immediate zero; skipped after a preceding load
            if (!skip_q) begin
               work_d = byte_i[3:0];
               zero_d = (byte_i[3:0] == 4'h0);
            end
         end else if (byte_i[7:2] == `HI_SMB) begin
            we_a    = 1'b1;
            wdata_a = m_hl | bit_mask;
         end else if (byte_i[7:2] == `HI_RMB) begin
            we_a    = 1'b1;
            wdata_a = m_hl & ~bit_mask;
            zero_d  = (wdata_a == 4'h0);
         end else if (byte_i[7:2] == `HI_LA && !byte_i[0]) begin
            work_d = m_sel;
            zero_d = (m_sel == 4'h0);
         end else begin
            unique case (byte_i)
               `OP_CMA: begin
                  work_d = ~work_q;
                  zero_d = (work_q == 4'hF);
               end
               `OP_RAR: begin
                  work_d  = {carry_q, work_q[3:1]};
                  carry_d = work_q[0];
               end
               `OP_RAL: begin
                  work_d  = {work_q[2:0], carry_q};
                  carry_d = work_q[3];
                  zero_d  = (work_d == 4'h0);
               end
               `OP_TAE: ext_d = work_q;
               `OP_TEA: begin
                  work_d = ext_q;
                  zero_d = (ext_q == 4'h0);
               end
               `OP_XAE: begin
                  work_d = ext_q;
                  ext_d  = work_q;
               end
               `OP_AD: begin
                  work_d  = add_mem[3:0];
                  carry_d = add_mem[4];
                  zero_d  = (work_d == 4'h0);
               end
               `OP_ADC: begin
                  work_d  = add_mem_c[3:0];
                  carry_d = add_mem_c[4];
                  zero_d  = (work_d == 4'h0);
               end
               `OP_BORROW_SUBTRACT_OP: begin
                  work_d  = sub_mem[3:0];
                  carry_d = ~sub_mem[4];
                  zero_d  = (work_d == 4'h0);
               end
               `OP_CONJ_TO_WORK_OP: begin
                  work_d = work_q & m_hl;
                  zero_d = (work_d == 4'h0);
               end
               `OP_ORA: begin
                  work_d = work_q | m_hl;
                  zero_d = (work_d == 4'h0);
               end
               `OP_EXL: begin
                  work_d = work_q ^ m_hl;
                  zero_d = (work_d == 4'h0);
               end
               `OP_CONJ_TO_MEM_OP: begin
                  we_a    = 1'b1;
                  wdata_a = work_q & m_hl;
                  zero_d  = (wdata_a == 4'h0);
               end
               `OP_ORM: begin
                  we_a    = 1'b1;
                  wdata_a = work_q | m_hl;
                  zero_d  = (wdata_a == 4'h0);
               end
               `OP_CM: begin
                  carry_d = (m_hl <= work_q);
                  zero_d  = (m_hl == work_q);
               end
               `OP_LAE: begin
                  work_d = m_hl;
                  ext_d  = mem_q[ptr_next];
               end
               `OP_SAE: begin
                  we_a    = 1'b1;
                  we_b    = 1'b1;
                  wdata_a = work_q;
               end
               default: ;
            endcase
         end
      end else if (exec_two) begin
         if (first_q == `OP_INC_DIRECT) begin
            we_a    = 1'b1;
            waddr_a = byte_i;
            wdata_a = inc_direct[3:0];
            carry_d = inc_direct[4];
            zero_d  = (wdata_a == 4'h0);
         end else if (first_q == `OP_DEC_DIRECT) begin
            we_a    = 1'b1;
            waddr_a = byte_i;
            wdata_a = dec_direct[3:0];
            carry_d = dec_direct[4];
            zero_d  = (wdata_a == 4'h0);
         end else if (first_q == `OP_EXT_GROUP) begin
            if (byte_i[7:4] == `SUB_ADI) begin
               // also serves the decimal adjusts with immediates 6 and A
               work_d = add_imm[3:0];
               zero_d = (add_imm[3:0] == 4'h0);
            end else if (byte_i[7:4] == `SUB_CI) begin
               carry_d = (byte_i[3:0] <= work_q);
               zero_d  = (byte_i[3:0] == work_q);
            end else if (byte_i[7:4] == `SUB_CLI) begin
               zero_d = (primary_pointer_low == byte_i[3:0]);
            end else if (sub_cmb) begin
               zero_d = ((work_q & bit_mask) == (m_hl & bit_mask));
            end
         end
      end
   end

   // ==========
   // axi4-lite slave decode
   logic [11:0] awaddr_q, raddr_d;
   logic [31:0] wdata_q, status_word, rdata_d;
   logic        have_aw_q, have_w_q, wstrb0_q;
   wire logic   aw_hs    = s_axi_awvalid && s_axi_awready;
   wire logic   w_hs     = s_axi_wvalid && s_axi_wready;
   wire logic   b_hs     = s_axi_bvalid && s_axi_bready;
   wire logic   ar_hs    = s_axi_arvalid && s_axi_arready;
   wire logic   r_hs     = s_axi_rvalid && s_axi_rready;
   wire logic   do_write = have_aw_q && have_w_q && !s_axi_bvalid;
   wire logic   wr_mem   = (awaddr_q[11:10] == `MEM_BASE_HI);
   wire logic   wr_pri   = (awaddr_q == `ADDR_PRIMARY);
   wire logic   wr_aux   = (awaddr_q == `ADDR_AUX);
   wire logic   wr_ok    = wr_mem || wr_pri || wr_aux;
   wire logic   bus_we   = do_write && wstrb0_q;
   wire logic   rd_mem   = (s_axi_araddr[11:10] == `MEM_BASE_HI);
   wire logic   rd_stat  = (s_axi_araddr == `ADDR_STATUS);
   wire logic   rd_pri   = (s_axi_araddr == `ADDR_PRIMARY);
   wire logic   rd_aux   = (s_axi_araddr == `ADDR_AUX);
   wire logic   rd_ok    = rd_mem || rd_stat || rd_pri || rd_aux;
   assign raddr_d = s_axi_araddr;
   assign status_word = {20'h00000, state_q == FETCH_SECOND, skip_q, zero_q, carry_q,
                         ext_q, work_q};
   assign rdata_d = rd_mem  ? {28'h0000000, mem_q[raddr_d[9:2]]} :
                    rd_stat ? status_word :
                    rd_pri  ? {24'h000000, primary_pointer_q} :
                    rd_aux  ? {24'h000000, auxiliary_pointer_q} : 32'h00000000;

   // ==========
   // architectural registers and fetch sequencing
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         work_q  <= 4'h0;
         ext_q   <= 4'h0;
         carry_q <= 1'b0;
         zero_q  <= 1'b0;
         skip_q  <= 1'b0;
         first_q <= 8'h00;
         state_q <= FETCH_FIRST;
      end else begin
         work_q  <= work_d;
         ext_q   <= ext_d;
         carry_q <= carry_d;
         zero_q  <= zero_d;
         if (byte_valid_i) begin
            skip_q <= !two_byte && is_lai;
            if (!two_byte && is_prefix) begin
               first_q <= byte_i;
               state_q <= FETCH_SECOND;
            end else begin
               state_q <= FETCH_FIRST;
            end
         end
      end
   end

   // pointers are loaded by software
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         primary_pointer_q   <= 8'h00;
         auxiliary_pointer_q <= 8'h00;
      end else begin
         if (bus_we && wr_pri) primary_pointer_q <= wdata_q[7:0];
         if (bus_we && wr_aux) auxiliary_pointer_q <= wdata_q[7:0];
      end
   end

   // data memory: execution writes take priority over the bus
   always_ff @(posedge mclk_i) begin
      if (we_a) begin
         mem_q[waddr_a] <= wdata_a;
      end else if (bus_we && wr_mem) begin
         mem_q[awaddr_q[9:2]] <= wdata_q[3:0];
      end
      if (we_b) mem_q[ptr_next] <= wdata_b;
   end

   // ==========
   // axi4-lite write channel
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         have_aw_q     <= 1'b0;
         have_w_q      <= 1'b0;
         awaddr_q      <= 12'h000;
         wdata_q       <= 32'h00000000;
         wstrb0_q      <= 1'b0;
      end else begin
         if (aw_hs) begin
            awaddr_q      <= s_axi_awaddr;
            have_aw_q     <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (w_hs) begin
            wdata_q      <= s_axi_wdata;
            wstrb0_q     <= s_axi_wstrb[0];
            have_w_q     <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (b_hs) begin
            s_axi_bvalid  <= 1'b0;
            have_aw_q     <= 1'b0;
            have_w_q      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // axi4-lite read channel
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else if (ar_hs) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rdata_d;
         s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (r_hs) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ==========
   // state outputs straight from registers
   assign work_reg_o  = work_q;
   assign ext_reg_o   = ext_q;
   assign carry_bit_o = carry_q;
   assign zero_bit_o  = zero_q;
   assign state_o     = state_q;
endmodule
`default_nettype wire

// file: shared/nibble_exec_pkg.sv
// types for the nibble execution unit
package nibble_exec_pkg;
   typedef enum logic [0:0] {
      FETCH_FIRST  = 1'b0,
      FETCH_SECOND = 1'b1
   } fetch_state_t;
   typedef logic [3:0] nibble_t;
endpackage

// file: shared/nibble_exec_regs.svh
// opcodes and register map of the nibble execution unit
// Functional notes
// - zero_work_op clears work_reg, sets zero_bit, vertical skip
// - decimal_fix_add_op adds six, zero_bit only
// - decimal_fix_sub_op adds ten, zero_bit only
// - invert_work_op complements work_reg, updates zero_bit
// - rotate_right_op through carry, carry only
// - rotate_left_op through carry, carry and zero
// - work/ext transfers and swap, flags as listed
// - direct increment/decrement memory at 8-bit address
// - bit set/clear at primary pointer; clear sets zero
// - add memory nibble to work_reg, zero and carry
// - add memory, work_reg and carry_bit
// - sum_immediate_op adds immediate, zero_bit only
// - memory minus work minus inverted carry
// - and/or/xor into work_reg, zero_bit updated
// - and/or into memory nibble, zero_bit updated
// - compare memory with work_reg, encoded flags
// - compare immediate with work_reg, same encoding
// - pointer low nibble equals immediate sets zero
// - selected bit of work and memory equal
// - pair load and pair store, two nibbles
// - immediate_load_op loads immediate, updates zero_bit
// - indirect fetch via primary or auxiliary pointer
`ifndef NIBBLE_EXEC_REGS_SVH
`define NIBBLE_EXEC_REGS_SVH

// ==========
// single byte opcodes
`define OP_RAL        8'h01
`define OP_ADC        8'h02
`define OP_CONJ_TO_MEM_OP       8'h03
`define OP_ORM        8'h04
`define OP_ORA        8'h05
`define OP_AD         8'h06
`define OP_CONJ_TO_WORK_OP       8'h07
`define OP_RAR        8'h10
`define OP_EXL        8'h15
`define OP_CM         8'h16
`define OP_BORROW_SUBTRACT_OP       8'h17
`define OP_CMA        8'h18
`define OP_XAE        8'h44
`define OP_TAE        8'h45
`define OP_TEA        8'h46
`define OP_LAE        8'h5C
`define OP_SAE        8'h5E
`define HI_SMB        6'h03
`define HI_RMB        6'h0B
`define HI_LA         6'h12
`define HI_LAI        4'h8
`define HI_PREFIX     4'hC

// ==========
// two byte opcodes: first byte, then second byte high nibble (top six bits for SUB_CMB)
`define OP_EXT_GROUP  8'hCF
`define OP_INC_DIRECT 8'hC7
`define OP_DEC_DIRECT 8'hC5
`define SUB_ADI       4'h2
`define SUB_CI        4'hA
`define SUB_CLI       4'hB
`define SUB_CMB       6'h34

// ==========
// register map (byte addresses)
`define ADDR_STATUS   12'h000
`define ADDR_PRIMARY  12'h004
`define ADDR_AUX      12'h008
`define MEM_BASE_HI   2'h1
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// file: tb/fetch_model.sv
// instruction byte source standing in for the program rom fetch path
`timescale 1ns/1ns
`default_nettype none
module fetch_model (
   // clock
   input  wire logic  clk_i,
   // byte stream
   output logic       byte_valid_o,
   output logic [7:0] byte_o
);
   // idle from time zero
   initial begin
      byte_valid_o = 1'h0;
      byte_o = 8'h00;
   end
   // one byte for one edge; an idle line shows the inverse of the last byte
   task automatic send(input logic [7:0] b, input int gap);
      byte_o <= b;
      byte_valid_o <= 1'h1;
      @(posedge clk_i);
      if (gap > 0) begin
         byte_valid_o <= 1'h0;
         byte_o <= ~b;
         repeat (gap) @(posedge clk_i);
      end
   endtask
endmodule
`default_nettype wire

// file: tb/nibble_exec_props.sv
// concurrent checks on the nibble execution unit ports
`timescale 1ns/1ns
`default_nettype none
module nibble_exec_props (
   // clock and reset
   input wire logic                          mclk_i,
   input wire logic                          resetn_i,
   // instruction stream
   input wire logic                          byte_valid_i,
   input wire logic [7:0]                    byte_i,
   // architectural state
   input wire logic [3:0]                    work_reg_o,
   input wire logic [3:0]                    ext_reg_o,
   input wire logic                          carry_bit_o,
   input wire logic                          zero_bit_o,
   input wire nibble_exec_pkg::fetch_state_t state_o,
   // write response
   input wire logic                          s_axi_bvalid,
   input wire logic                          s_axi_bready
);
   import nibble_exec_pkg::*;
   logic exec_w, skip_q;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   // ==========
   // skip tracking: an executed immediate load arms it, any other byte ends it
   assign exec_w = byte_valid_i && (state_o == FETCH_FIRST);
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) skip_q <= 1'h0;
      else if (byte_valid_i) skip_q <= exec_w && (byte_i[7:4] == 4'h8);
   end
   // ==========
   // properties
   property p_load_imm;
      exec_w && byte_i[7:4] == 4'h8 && !skip_q |=>
         work_reg_o == $past(byte_i[3:0]) && zero_bit_o == (work_reg_o == 4'h0);
   endproperty
   a_load_imm: assert property (p_load_imm) else $error("immediate load wrong");
   property p_vert_skip;
      exec_w && byte_i[7:4] == 4'h8 && skip_q |=> $stable(work_reg_o) && $stable(zero_bit_o);
   endproperty
   a_vert_skip: assert property (p_vert_skip) else $error("skipped load acted");
   property p_invert;
      exec_w && byte_i == 8'h18 |=> work_reg_o == ~$past(work_reg_o)
         && zero_bit_o == (work_reg_o == 4'h0) && $stable(carry_bit_o);
   endproperty
   a_invert: assert property (p_invert) else $error("complement wrong");
   property p_rot_right;
      exec_w && byte_i == 8'h10 |=> work_reg_o == {$past(carry_bit_o), $past(work_reg_o[3:1])}
         && carry_bit_o == $past(work_reg_o[0]) && $stable(zero_bit_o);
   endproperty
   a_rot_right: assert property (p_rot_right) else $error("rotate right wrong");
   property p_rot_left;
      exec_w && byte_i == 8'h01 |=> work_reg_o == {$past(work_reg_o[2:0]), $past(carry_bit_o)}
         && carry_bit_o == $past(work_reg_o[3]) && zero_bit_o == (work_reg_o == 4'h0);
   endproperty
   a_rot_left: assert property (p_rot_left) else $error("rotate left wrong");
   property p_swap;
      exec_w && byte_i == 8'h44 |=> work_reg_o == $past(ext_reg_o)
         && ext_reg_o == $past(work_reg_o) && $stable(carry_bit_o) && $stable(zero_bit_o);
   endproperty
   a_swap: assert property (p_swap) else $error("swap wrong");
   property p_ext_to_work;
      exec_w && byte_i == 8'h46 |=> work_reg_o == ext_reg_o && zero_bit_o == (ext_reg_o == 4'h0);
   endproperty
   a_ext_to_work: assert property (p_ext_to_work) else $error("ext transfer wrong");
   property p_first_byte;
      exec_w && byte_i[7:4] == 4'hC |=> state_o == FETCH_SECOND && $stable(work_reg_o);
   endproperty
   a_first_byte: assert property (p_first_byte) else $error("prefix not held");
   property p_second_byte;
      byte_valid_i && state_o == FETCH_SECOND |=> state_o == FETCH_FIRST;
   endproperty
   a_second_byte: assert property (p_second_byte) else $error("pair not closed");
   // main scenarios reached
   c_skip: cover property (exec_w && byte_i[7:4] == 4'h8 && skip_q);
   c_pair: cover property (byte_valid_i && state_o == FETCH_SECOND);
   c_bresp: cover property (s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the nibble execution unit
`timescale 1ns/1ns
`default_nettype none
bind nibble_exec nibble_exec_props i_props (.mclk_i, .resetn_i, .byte_valid_i, .byte_i,
   .work_reg_o, .ext_reg_o, .carry_bit_o, .zero_bit_o, .state_o, .s_axi_bvalid, .s_axi_bready);
module testbench;
   import nibble_exec_pkg::*;
   logic         mclk_i, resetn_i, byte_valid_i, carry_bit_o, zero_bit_o;
   logic [7:0]   byte_i, b, b2;
   logic [3:0]   work_reg_o, ext_reg_o, s_axi_wstrb;
   fetch_state_t state_o;
   logic [11:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0]  s_axi_wdata, s_axi_rdata, d;
   logic [1:0]   s_axi_bresp, s_axi_rresp, r;
   logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [3:0]   subs [4] = '{4'h2, 4'hA, 4'hB, 4'hD};
   logic [7:0]   ops [32];
   int           w, e, c, z, p, a, skip, pend, first_b, g, errors, n_compared;
   int           mem_m [256];
   nibble_exec i_dut (.mclk_i, .resetn_i, .byte_valid_i, .byte_i, .work_reg_o, .ext_reg_o,
      .carry_bit_o, .zero_bit_o, .state_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   fetch_model i_fetch (.clk_i(mclk_i), .byte_valid_o(byte_valid_i), .byte_o(byte_i));
   // ==========
   // bus master, responses always accepted
   task automatic axi_wr(input logic [11:0] ad, input logic [31:0] dt, input logic [3:0] st,
                         output logic [1:0] rs);
      bit aw_ok, w_ok;
      s_axi_awaddr <= ad;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata <= dt;
      s_axi_wstrb <= st;
      s_axi_wvalid <= 1'h1;
      while (!(aw_ok && w_ok)) begin
         @(posedge mclk_i);
         if (!aw_ok && s_axi_awready === 1'h1) begin
            aw_ok = 1;
            s_axi_awvalid <= 1'h0;
         end
         if (!w_ok && s_axi_wready === 1'h1) begin
            w_ok = 1;
            s_axi_wvalid <= 1'h0;
         end
      end
      do @(posedge mclk_i); while (s_axi_bvalid !== 1'h1);
      rs = s_axi_bresp;
   endtask
   task automatic axi_rd(input logic [11:0] ad, output logic [31:0] dt, output logic [1:0] rs);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'h1;
      do @(posedge mclk_i); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge mclk_i); while (s_axi_rvalid !== 1'h1);
      dt = s_axi_rdata;
      rs = s_axi_rresp;
   endtask
   // ==========
   // comparisons
   task automatic cmp_bus(input logic [31:0] got, input logic [31:0] ex);
      n_compared++;
      if (got !== ex) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, ex);
      end
   endtask
   task automatic cmp_state();
      cmp_bus({21'h0, state_o, zero_bit_o, carry_bit_o, ext_reg_o, work_reg_o},
              {21'h0, 1'(pend), 1'(z), 1'(c), 4'(e), 4'(w)});
   endtask
   // reference model of one taken byte
   task automatic model_exec(input logic [7:0] bt);
      int m, s;
      m = mem_m[p];
      if (pend) begin
         pend = 0;
         skip = 0;
         case (first_b)
            8'hC7: begin s = mem_m[bt] + 1; c = s >> 4; mem_m[bt] = s & 15; z = (s & 15) == 0; end
            8'hC5: begin c = mem_m[bt] != 0; mem_m[bt] = (mem_m[bt] + 15) & 15;
               z = mem_m[bt] == 0; end
            8'hCF: case (bt[7:4])
               4'h2: begin w = (w + bt[3:0]) & 15; z = w == 0; end
               4'hA: begin c = bt[3:0] <= w; z = bt[3:0] == w; end
               4'hB: z = (p & 15) == bt[3:0];
               4'hD: z = ((w >> bt[1:0]) & 1) == ((m >> bt[1:0]) & 1);
               default: ;
            endcase
            default: ;
         endcase
      end else if (bt[7:4] == 4'hC) begin pend = 1; first_b = bt; skip = 0; end
      else if (bt[7:4] == 4'h8) begin
         if (!skip) begin w = bt[3:0]; z = w == 0; end
         skip = 1;
      end else begin
         skip = 0;
         case (bt)
            8'h01: begin s = w * 2 + c; c = s >> 4; w = s & 15; z = w == 0; end
            8'h02: begin s = w + m + c; c = s >> 4; w = s & 15; z = w == 0; end
            8'h06: begin s = w + m; c = s >> 4; w = s & 15; z = w == 0; end
            8'h03: begin mem_m[p] = w & m; z = mem_m[p] == 0; end
            8'h04: begin mem_m[p] = w | m; z = mem_m[p] == 0; end
            8'h05: begin w = w | m; z = w == 0; end
            8'h07: begin w = w & m; z = w == 0; end
            8'h15: begin w = w ^ m; z = w == 0; end
            8'h10: begin s = c * 8 + (w >> 1); c = w & 1; w = s; end
            8'h16: begin c = m <= w; z = m == w; end
            8'h17: begin s = m - w - (1 - c); c = s >= 0; w = s & 15; z = w == 0; end
            8'h18: begin w = ~w & 15; z = w == 0; end
            8'h44: begin s = w; w = e; e = s; end
            8'h45: e = w;
            8'h46: begin w = e; z = w == 0; end
            8'h48: begin w = m; z = w == 0; end
            8'h4A: begin w = mem_m[a]; z = w == 0; end
            8'h5C: begin w = m; e = mem_m[(p + 1) & 255]; end
            8'h5E: begin mem_m[p] = w; mem_m[(p + 1) & 255] = e; end
            8'h0C, 8'h0D, 8'h0E, 8'h0F: mem_m[p] = m | (1 << bt[1:0]);
            8'h2C, 8'h2D, 8'h2E, 8'h2F: begin mem_m[p] = m & ~(1 << bt[1:0]) & 15;
               z = mem_m[p] == 0; end
            default: ;
         endcase
      end
   endtask
   // present a byte, let its edge land, then compare
   task automatic step(input logic [7:0] bt, input int gp);
      i_fetch.send(bt, gp);
      model_exec(bt);
      fork
         #1 cmp_state();
      join_none
   endtask
   task automatic set_ptrs();
      p = $urandom % 256;
      a = $urandom % 256;
      axi_wr(12'h004, 32'(p), 4'hF, r);
      cmp_bus(32'(r), 32'h0);
      axi_wr(12'h008, 32'(a), 4'hF, r);
   endtask
   task automatic stop_test();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========
   // clock, watchdog and main sequence
   initial begin
      mclk_i = 1'h0;
      forever #20 mclk_i = ~mclk_i;
   end
   initial begin
      #800000;
      errors++;
      $display("BAD %0t watchdog expired", $time);
      stop_test();
   end
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      s_axi_bready = 1'h1;
      s_axi_rready = 1'h1;
      resetn_i = 1'h0;
      {w, e, c, z, skip, pend, errors, n_compared} = '0;
      ops = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h10, 8'h15, 8'h16, 8'h17,
              8'h18, 8'h44, 8'h45, 8'h46, 8'h48, 8'h4A, 8'h5C, 8'h5E, 8'h0C, 8'h0D, 8'h0E,
              8'h0F, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h80, 8'h8A, 8'hCF, 8'hC7, 8'hC5};
      d = $urandom(32'h1623A01D);
      repeat (3) @(posedge mclk_i);
      resetn_i <= 1'h1;
      for (int i = 0; i < 256; i++) begin
         mem_m[i] = $urandom % 16;
         axi_wr(12'h400 + 12'(i * 4), 32'(mem_m[i]), 4'hF, r);
      end
      set_ptrs();
      step(8'h85, 0);
      step(8'h80, 0);
      step(8'h18, 0);
      step(8'h80, 0);
      step(8'hCF, 0);
      step(8'h26, 0);
      step(8'hCF, 0);
      step(8'h2A, 1);
      for (int k = 0; k < 512; k++) begin
         g = (k % 64 == 63) ? 1 : $urandom % 3;
         b = ops[$urandom % 32];
         if (b[7:4] == 4'h8) b[3:0] = 4'($urandom);
         b2 = 8'($urandom);
         if (b == 8'hCF) b2[7:4] = subs[$urandom % 4];
         if (b2[7:4] == 4'hD) b2[3:2] = 2'h0;
         step(b, (b[7:4] == 4'hC) ? $urandom % 2 : g);
         if (b[7:4] == 4'hC) step(b2, g);
         if (k % 64 == 63) set_ptrs();
      end
      axi_rd(12'h000, d, r);
      cmp_bus(d, {20'h0, 1'(pend), 1'(skip), 1'(z), 1'(c), 4'(e), 4'(w)});
      axi_wr(12'h004, 32'h5A, 4'h0, r);
      axi_rd(12'h004, d, r);
      cmp_bus(d, 32'(p));
      axi_wr(12'h000, 32'h0, 4'hF, r);
      cmp_bus(32'(r), 32'h2);
      axi_rd(12'h00C, d, r);
      cmp_bus({d[29:0], r}, 32'h2);
      for (int i = 0; i < 256; i++) begin
         axi_rd(12'h400 + 12'(i * 4), d, r);
         cmp_bus(d, 32'(mem_m[i]));
      end
      stop_test();
   end
endmodule
`default_nettype wire
